// *** common/flash_cmd_pkg.sv ***
// Constants, field positions and types of the flash command controller
package flash_cmd_pkg;
  // ==========================================
  // Register offsets
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFS_CLKDIV = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PIDX = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_CFG = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_ERRCFG = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_STAT = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_ERRSTAT = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_PPROT = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_DPROT = 5'h09;
  localparam logic [ADDR_W-1:0] OFS_PHI = 5'h0A;
  localparam logic [ADDR_W-1:0] OFS_PLO = 5'h0B;
  localparam logic [ADDR_W-1:0] OFS_VER = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_INFO = 5'h0D;
  // ==========================================
  // Field positions
  localparam int BIT_CMD_DONE_IRQ_ENABLE = 7;
  localparam int BIT_IGNORE_SINGLE_FAULT = 4;
  localparam int BIT_FORCE_DOUBLE_FAULT = 1;
  localparam int BIT_FORCE_SINGLE_FAULT = 0;
  localparam int BIT_DFD = 1;
  localparam int BIT_SFD = 0;
  localparam int BIT_CMD_DONE_FLAG = 7;
  localparam int BIT_ACCESS_ERROR = 5;
  localparam int BIT_PVIOL = 4;
  localparam int BIT_FAIL = 0;
  localparam int BIT_DIVLD = 7;
  localparam int BIT_PROGRAM_PROTECT_OPEN = 7;
  localparam int BIT_HIGH_REGION_PROTECT_OFF = 5;
  localparam int BIT_LOW_REGION_PROTECT_OFF = 2;
  localparam int BIT_DATA_PROTECT_OPEN = 7;
  localparam int BIT_EEBLK = 7;
  localparam logic [7:0] CFG_MASK = 8'h93;
  // ==========================================
  // Reset values and sizes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam int DIV_W = 6;
  localparam int PARAM_WORDS = 6;
  localparam int INFO_BYTES = 64;
  localparam logic [3:0] VER_FIRST = 4'h1;
  localparam logic [3:0] VER_NONE0 = 4'h0;
  localparam logic [3:0] VER_NONE1 = 4'hF;
  // ==========================================
  // Command codes
  localparam logic [7:0] CMD_EVBLK = 8'h02;
  localparam logic [7:0] CMD_EVSEC = 8'h03;
  localparam logic [7:0] CMD_RONCE = 8'h04;
  localparam logic [7:0] CMD_PROG = 8'h06;
  localparam logic [7:0] CMD_PONCE = 8'h07;
  localparam logic [7:0] CMD_ERSALL = 8'h08;
  localparam logic [7:0] CMD_ERSBLK = 8'h09;
  localparam logic [7:0] CMD_ERSSEC = 8'h0A;
  localparam logic [7:0] CMD_UNSEC = 8'h0B;
  localparam logic [7:0] CMD_VKEY = 8'h0C;
  localparam logic [7:0] CMD_SUML = 8'h0D;
  localparam logic [7:0] CMD_SFML = 8'h0E;
  typedef enum {ST_IDLE, ST_RUN, ST_LOCAL} seq_state_t;
endpackage

// *** src/flash_command_controller.sv ***
// Command and configuration front end of the on-chip flash controller
// How it works
// - Config register keeps only bits 7,4,1,0; others read zero, ignore writes.
// - Command-done interrupt requested while done flag and its enable are set.
// - Ignore-single-fault bit suppresses recording single faults and their interrupt.
// - Force-double-fault bit makes every array read set the double-fault flag.
// - Force-single-fault bit makes every array read set the single-fault flag unless ignore-single-fault is set.
// - Error config holds both fault enables; interrupt needs flag and enable.
// - Four-bit version, first is one, zero and all-ones mean none.
// - Info region readable only while its map select is active.
// - Writing the divider sets divider-loaded; zero from reset until then.
// - Program or erase without loaded divider is refused with access error.
// - A valid command entered through the write sequence is launched only while both error flags are clear.
// - While busy, no new launch and parameter writes are ignored.
// - Codes 02 and 03 verify a block or a word range is erased.
// - Code 07 programs the 64-byte field once; 04 reads it back.
// - Code 06 programs one phrase at the supplied address.
// - Code 08 erases all; needs all protection-off bits set beforehand.
// - Code 09 erases a block; full program block needs protection off.
// - Code 0A erases one sector at the supplied address.
// - Codes 0B and 0C release security by erase or key check.
// - Codes 0D and 0E set margin levels; 0E only in special mode.
`timescale 1ns/1ps
module flash_command_controller #(
  parameter logic [3:0] VERSION = flash_cmd_pkg::VER_FIRST
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [flash_cmd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Device mode
  input wire logic info_region_map_select,
  input wire logic special_mode,
  // Array engine
  output logic op_start,
  output logic [7:0] op_code,
  output logic [15:0] op_addr,
  output logic [15:0] op_data,
  input wire logic op_done,
  input wire logic op_fail,
  // Array read checks
  input wire logic array_read,
  input wire logic ecc_single,
  input wire logic ecc_double,
  // Time base and results
  output logic program_time_base,
  output logic [1:0] margin_level,
  output logic cmd_done_irq,
  output logic error_irq
);
  import flash_cmd_pkg::*;

  // ==========================================
  // Command classes
  function automatic logic is_prog_erase(input logic [7:0] c);
    return c == CMD_PROG || c == CMD_PONCE || c == CMD_ERSALL || c == CMD_ERSBLK || c == CMD_ERSSEC || c == CMD_UNSEC;
  endfunction
  function automatic logic is_defined(input logic [7:0] c);
    return is_prog_erase(c) || c == CMD_EVBLK || c == CMD_EVSEC ||
           c == CMD_RONCE || c == CMD_VKEY || c == CMD_SUML || c == CMD_SFML;
  endfunction
  function automatic logic is_local(input logic [7:0] c);
    return c == CMD_RONCE || c == CMD_PONCE || c == CMD_SUML || c == CMD_SFML;
  endfunction

  // ==========================================
  // State
  logic [DIV_W-1:0] divider_value;
  logic divider_loaded;
  logic [DIV_W-1:0] tb_cnt;
  logic [2:0] param_idx;
  logic [15:0] param [PARAM_WORDS];
  logic [7:0] flash_configuration;
  logic [1:0] error_irq_config;
  logic [1:0] error_status;
  logic cmd_done_flag;
  logic access_error;
  logic protection_violation;
  logic op_failed;
  logic [7:0] program_protection;
  logic [7:0] data_protection;
  logic [7:0] info_region [INFO_BYTES];
  logic [INFO_BYTES-1:0] info_written;
  seq_state_t state;
  seq_state_t next_state;
  logic [7:0] rd_mux;
  // ==========================================
  // Write decode
  wire w_div = reg_wr && reg_addr == OFS_CLKDIV;
  wire w_idx = reg_wr && reg_addr == OFS_PIDX && cmd_done_flag;
  wire w_cfg = reg_wr && reg_addr == OFS_CFG;
  wire w_ecfg = reg_wr && reg_addr == OFS_ERRCFG;
  wire w_stat = reg_wr && reg_addr == OFS_STAT;
  wire w_estat = reg_wr && reg_addr == OFS_ERRSTAT;
  wire w_pprot = reg_wr && reg_addr == OFS_PPROT;
  wire w_dprot = reg_wr && reg_addr == OFS_DPROT;
  wire idx_ok = 32'(param_idx) < PARAM_WORDS;
  wire w_phi = reg_wr && reg_addr == OFS_PHI && cmd_done_flag && idx_ok;
  wire w_plo = reg_wr && reg_addr == OFS_PLO && cmd_done_flag && idx_ok;
  // ==========================================
  // Launch checks
  wire [7:0] cmd = param[0][15:8];
  wire [5:0] oidx = param[1][5:0];
  wire ignore_sf = flash_configuration[BIT_IGNORE_SINGLE_FAULT];
  // Both error flags must be clear and no sequence active
  wire launch = w_stat && reg_wdata[BIT_CMD_DONE_FLAG] && cmd_done_flag &&
                !access_error && !protection_violation;
  wire bad_code = !is_defined(cmd);
  wire no_div = is_prog_erase(cmd) && !divider_loaded;
  wire bad_mode = cmd == CMD_SFML && !special_mode;
  wire once_used = cmd == CMD_PONCE && info_written[oidx];
  wire acc_fail = launch && (bad_code || no_div || bad_mode || once_used);
  wire prot_off = program_protection[BIT_PROGRAM_PROTECT_OPEN] &&
                  program_protection[BIT_HIGH_REGION_PROTECT_OFF] && program_protection[BIT_LOW_REGION_PROTECT_OFF];
  wire all_fail = cmd == CMD_ERSALL && !(prot_off && data_protection[BIT_DATA_PROTECT_OPEN]);
  // Block select bit high picks the data block, which needs no check
  wire blk_fail = cmd == CMD_ERSBLK && !param[0][BIT_EEBLK] && !prot_off;
  wire prot_fail = launch && !acc_fail && (all_fail || blk_fail);
  wire go = launch && !acc_fail && !prot_fail;
  wire go_local = go && is_local(cmd);
  wire go_array = go && !is_local(cmd);
  // ==========================================
  // Flag next values; a set beats a same-cycle clear
  wire next_acc = acc_fail || (access_error && !(w_stat && reg_wdata[BIT_ACCESS_ERROR]));
  wire next_pviol = prot_fail || (protection_violation && !(w_stat && reg_wdata[BIT_PVIOL]));
  wire sf_hit = array_read && !ignore_sf && (ecc_single || flash_configuration[BIT_FORCE_SINGLE_FAULT]);
  wire df_hit = array_read && (ecc_double || flash_configuration[BIT_FORCE_DOUBLE_FAULT]);
  wire [1:0] next_estat = {df_hit, sf_hit} | (error_status & ~(w_estat ? reg_wdata[1:0] : 2'h0));
  wire next_fail = go ? 1'b0 : (op_failed || (state == ST_RUN && op_done && op_fail));
  wire ver_present = VERSION != VER_NONE0 && VERSION != VER_NONE1;
  wire tb_wrap = tb_cnt == divider_value;
  // ==========================================
  // Sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (go_array)
          next_state = ST_RUN;
        else if (go_local)
          next_state = ST_LOCAL;
      end
      ST_RUN:
      begin
        if (op_done)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      cmd_done_flag <= 1'b1;
      access_error <= 1'b0;
      protection_violation <= 1'b0;
      op_failed <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd_done_flag <= next_state == ST_IDLE;
      access_error <= next_acc;
      protection_violation <= next_pviol;
      op_failed <= next_fail;
    end
  end
  // ==========================================
  // Array engine hand-off
  // Codes 02 03 06 08 09 0A 0B 0C run on the array engine
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      op_start <= 1'b0;
      op_code <= RST_BYTE;
      op_addr <= RST_WORD;
      op_data <= RST_WORD;
    end
    else
    begin
      op_start <= go_array;
      if (go_array)
      begin
        op_code <= cmd;
        op_addr <= param[1];
        op_data <= param[2];
      end
    end
  end
  // ==========================================
  // Configuration and protection registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      divider_value <= '0;
      divider_loaded <= 1'b0;
      flash_configuration <= RST_BYTE;
      error_irq_config <= 2'h0;
      error_status <= 2'h0;
      program_protection <= RST_BYTE;
      data_protection <= RST_BYTE;
      param_idx <= 3'h0;
    end
    else
    begin
      if (w_div)
      begin
        divider_value <= reg_wdata[DIV_W-1:0];
        divider_loaded <= 1'b1;
      end
      if (w_cfg)
        flash_configuration <= reg_wdata & CFG_MASK;
      if (w_ecfg)
        error_irq_config <= reg_wdata[1:0];
      error_status <= next_estat;
      if (w_pprot)
        program_protection <= reg_wdata;
      if (w_dprot)
        data_protection <= reg_wdata;
      if (w_idx)
        param_idx <= reg_wdata[2:0];
    end
  end
  // ==========================================
  // Command parameters and local commands
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < PARAM_WORDS; i++)
        param[i] <= RST_WORD;
      info_written <= '0;
      margin_level <= 2'h0;
    end
    else
    begin
      if (w_phi)
        param[param_idx][15:8] <= reg_wdata;
      if (w_plo)
        param[param_idx][7:0] <= reg_wdata;
      if (go_local && cmd == CMD_PONCE)
        info_written[oidx] <= 1'b1;
      if (go_local && cmd == CMD_RONCE)
        param[2] <= {RST_BYTE, info_region[oidx]};
      if (go_local && (cmd == CMD_SUML || cmd == CMD_SFML))
        margin_level <= param[1][1:0];
    end
  end
  // Storage only; no reset so it maps onto plain memory
  always_ff @(posedge clk_sys)
  begin
    if (go_local && cmd == CMD_PONCE)
      info_region[oidx] <= param[2][7:0];
  end
  // ==========================================
  // Program time base
  // Runs only once loaded, so no tick comes from a stale divider
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !divider_loaded)
    begin
      tb_cnt <= '0;
      program_time_base <= 1'b0;
    end
    else
    begin
      tb_cnt <= tb_wrap ? '0 : tb_cnt + 1'b1;
      program_time_base <= tb_wrap;
    end
  end

  // ==========================================
  // Interrupts
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cmd_done_irq <= 1'b0;
      error_irq <= 1'b0;
    end
    else
    begin
      cmd_done_irq <= cmd_done_flag && flash_configuration[BIT_CMD_DONE_IRQ_ENABLE];
      error_irq <= |(error_status & error_irq_config);
    end
  end

  // ==========================================
  // Read path
  always_comb
  begin
    rd_mux = RST_BYTE;
    if (reg_addr == OFS_CLKDIV)
      rd_mux = {divider_loaded, 1'b0, divider_value};
    else if (reg_addr == OFS_PIDX)
      rd_mux = {5'h00, param_idx};
    else if (reg_addr == OFS_CFG)
      rd_mux = flash_configuration;
    else if (reg_addr == OFS_ERRCFG)
      rd_mux = {6'h00, error_irq_config};
    else if (reg_addr == OFS_STAT)
      rd_mux = {cmd_done_flag, 1'b0, access_error, protection_violation, !cmd_done_flag, 2'h0, op_failed};
    else if (reg_addr == OFS_ERRSTAT)
      rd_mux = {6'h00, error_status};
    else if (reg_addr == OFS_PPROT)
      rd_mux = program_protection;
    else if (reg_addr == OFS_DPROT)
      rd_mux = data_protection;
    else if (reg_addr == OFS_PHI && idx_ok)
      rd_mux = param[param_idx][15:8];
    else if (reg_addr == OFS_PLO && idx_ok)
      rd_mux = param[param_idx][7:0];
    else if (reg_addr == OFS_VER)
      rd_mux = {3'h0, ver_present, VERSION};
    else if (reg_addr == OFS_INFO && info_region_map_select)
      rd_mux = info_region[oidx];
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      reg_rdata <= RST_BYTE;
    else
      reg_rdata <= reg_rd ? rd_mux : RST_BYTE;
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_CFG_ZERO: assert property (
    reg_rd && reg_addr == OFS_CFG |=> (reg_rdata & ~CFG_MASK) == 8'h00)
    else $error("config reserved bits not zero");
  AST_DONE_IRQ: assert property (
    cmd_done_flag && flash_configuration[BIT_CMD_DONE_IRQ_ENABLE] |=> cmd_done_irq)
    else $error("command done interrupt missing");
  AST_IGNORE_SF: assert property (
    $rose(error_status[BIT_SFD]) |-> !$past(ignore_sf))
    else $error("single fault recorded while ignored");
  AST_FORCE_DF: assert property (
    array_read && flash_configuration[BIT_FORCE_DOUBLE_FAULT] |=> error_status[BIT_DFD])
    else $error("forced double fault not flagged");
  AST_FORCE_SF: assert property (
    array_read && flash_configuration[BIT_FORCE_SINGLE_FAULT] && !ignore_sf |=> error_status[BIT_SFD])
    else $error("forced single fault not flagged");
  AST_ERR_IRQ: assert property (
    error_irq |-> $past(|(error_status & error_irq_config)))
    else $error("error interrupt without enabled flag");
  AST_INFO_MAP: assert property (
    reg_rd && reg_addr == OFS_INFO && !info_region_map_select
    |=> reg_rdata == 8'h00)
    else $error("info region read while unmapped");
  AST_DIV_LOADED: assert property (
    $rose(divider_loaded) |-> $past(w_div))
    else $error("divider loaded without a write");
  AST_NO_DIV: assert property (
    launch && no_div |=> access_error && cmd_done_flag && !op_start)
    else $error("program or erase ran without divider");
  AST_LAUNCH: assert property (
    go_array |=> op_start && !cmd_done_flag ##1 !op_start)
    else $error("valid command not launched");
  AST_BUSY_PARAM: assert property (
    !cmd_done_flag && reg_wr && (reg_addr == OFS_PHI || reg_addr == OFS_PLO) && idx_ok |=> $stable(param[param_idx]))
    else $error("parameter written while busy");
  AST_ERASE_ALL: assert property (
    launch && cmd == CMD_ERSALL && !data_protection[BIT_DATA_PROTECT_OPEN] && !acc_fail
    |=> protection_violation && !op_start)
    else $error("erase all ran while protected");
  AST_FIELD_MODE: assert property (
    launch && cmd == CMD_SFML && !special_mode |=> access_error)
    else $error("field margin accepted outside special mode");
  AST_BAD_CODE: assert property (
    launch && bad_code |=> access_error && !op_start)
    else $error("undefined command not refused");
  COV_ARRAY_CMD: cover property (go_array ##[1:50] op_done);
  COV_LOCAL_CMD: cover property (go_local && cmd == CMD_PONCE);
  COV_PROT_FAIL: cover property (prot_fail);
  COV_FAULT_IRQ: cover property (df_hit ##2 error_irq);
endmodule // flash_command_controller

// *** sim/array_engine_model.sv ***
// Behavioural array engine that answers launched commands
`timescale 1ns/1ps
module array_engine_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Launch side
  input wire logic op_start,
  input wire logic slow,
  input wire logic fail,
  // Completion side
  output logic op_done,
  output logic op_fail
);
  // ==========================================
  // Completion timer
  // Slow answers keep the controller busy long enough to poke it
  int left = 0;
  wire finish_now = !sys_rst && !op_start && left == 1;
  always @(posedge clk_sys)
  begin
    op_done <= finish_now;
    op_fail <= finish_now && fail;
    if (sys_rst || finish_now)
      left <= 0;
    else if (op_start)
      left <= slow ? 20 : 2;
    else if (left > 1)
      left <= left - 1;
  end
endmodule // array_engine_model

// *** sim/tb.sv ***
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH t=%0t %s", $time, m); end end
module tb;
  import flash_cmd_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic map_sel = 1'b0;
  logic special_mode = 1'b0;
  logic array_read = 1'b0;
  logic ecc_single = 1'b0;
  logic ecc_double = 1'b0;
  logic slow = 1'b0;
  logic engine_fail = 1'b0;
  logic op_start, op_done, op_fail, program_time_base, cmd_done_irq, error_irq;
  logic [7:0] op_code;
  logic [15:0] op_addr, op_data;
  logic [1:0] margin_level;
  int fail_count = 0;
  int samples_checked = 0;
  int starts = 0;
  logic [7:0] codes [8] = '{CMD_EVBLK, CMD_EVSEC, CMD_PROG, CMD_ERSALL, CMD_ERSBLK, CMD_ERSSEC, CMD_UNSEC, CMD_VKEY};

  flash_command_controller dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .info_region_map_select(map_sel), .special_mode(special_mode), .op_start(op_start),
    .op_code(op_code), .op_addr(op_addr), .op_data(op_data), .op_done(op_done), .op_fail(op_fail),
    .array_read(array_read), .ecc_single(ecc_single), .ecc_double(ecc_double),
    .program_time_base(program_time_base), .margin_level(margin_level),
    .cmd_done_irq(cmd_done_irq), .error_irq(error_irq));
  array_engine_model engine (.clk_sys(clk_sys), .sys_rst(sys_rst), .op_start(op_start),
    .slow(slow), .fail(engine_fail), .op_done(op_done), .op_fail(op_fail));

  // ==========================================
  // Clock, launch counter, watchdog
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    if (op_start === 1'b1)
      starts++;
  initial
  begin
    #200000;
    fail_count++;
    report_and_stop;
  end

  // ==========================================
  // Register port, array read fault and report tasks
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string m);
    logic [7:0] v;
    rd(a, v);
    `CHK(v, e, m)
  endtask
  task automatic word(input logic [2:0] i, input logic [15:0] w);
    wr(OFS_PIDX, {5'h00, i});
    wr(OFS_PHI, w[15:8]);
    wr(OFS_PLO, w[7:0]);
  endtask
  task automatic launch(input logic [7:0] c, input logic [15:0] w1, input logic [15:0] w2);
    word(3'd0, {c, 8'h00});
    word(3'd1, w1);
    word(3'd2, w2);
    wr(OFS_STAT, 8'h80);
  endtask
  task automatic wait_done;
    logic [7:0] v;
    v = 8'h00;
    for (int n = 0; n < 100 && v[7] !== 1'b1; n++)
      rd(OFS_STAT, v);
  endtask
  task automatic fault(input logic s, input logic d);
    @(posedge clk_sys);
    array_read <= 1'b1;
    ecc_single <= s;
    ecc_double <= d;
    @(posedge clk_sys);
    array_read <= 1'b0;
    ecc_single <= 1'b0;
    ecc_double <= 1'b0;
  endtask

  // ==========================================
  // Test sequence
  initial
  begin
    int n;
    int s;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk_rd(OFS_STAT, 8'h80, "status reset");
    chk_rd(OFS_CLKDIV, 8'h00, "divider reset");
    chk_rd(OFS_VER, 8'h11, "version");
    chk_rd(5'h1F, 8'h00, "unmapped read");
    wr(OFS_CFG, 8'hFF);
    chk_rd(OFS_CFG, 8'h93, "config mask");
    wr(OFS_CFG, 8'h00);
    launch(CMD_PROG, 16'h0000, 16'h0000);
    chk_rd(OFS_STAT, 8'hA0, "prog without divider");
    `CHK(starts, 0, "start without divider")
    wr(OFS_STAT, 8'h30);
    wr(OFS_CLKDIV, 8'h05);
    chk_rd(OFS_CLKDIV, 8'h85, "divider loaded");
    @(posedge program_time_base);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1 n++;
    end while (program_time_base !== 1'b1 && n < 50);
    `CHK(n, 6, "time base period")
    launch(8'h01, 16'h0000, 16'h0000);
    chk_rd(OFS_STAT, 8'hA0, "undefined code");
    wr(OFS_STAT, 8'h30);
    launch(CMD_ERSALL, 16'h0000, 16'h0000);
    chk_rd(OFS_STAT, 8'h90, "erase all protected");
    wr(OFS_STAT, 8'h30);
    wr(OFS_PPROT, 8'hA4);
    wr(OFS_DPROT, 8'h80);
    wr(OFS_CFG, 8'h80);
    slow <= 1'b1;
    launch(CMD_PROG, 16'h1234, 16'hBEEF);
    chk_rd(OFS_STAT, 8'h08, "busy status");
    `CHK(cmd_done_irq, 1'b0, "done irq while busy")
    wr(OFS_STAT, 8'h80);
    word(3'd1, 16'hFFFF);
    wait_done;
    `CHK(starts, 1, "one launch")
    `CHK(op_addr, 16'h1234, "phrase address")
    `CHK(op_data, 16'hBEEF, "phrase data")
    repeat (2) @(posedge clk_sys);
    `CHK(cmd_done_irq, 1'b1, "done irq")
    wr(OFS_PIDX, 8'h01);
    chk_rd(OFS_PHI, 8'h12, "busy write ignored");
    slow <= 1'b0;
    foreach (codes[i])
    begin
      s = starts;
      launch(codes[i], 16'h0100, 16'hA5A5);
      wait_done;
      `CHK(starts, s + 1, "array launch")
      `CHK(op_code, codes[i], "array code")
    end
    engine_fail <= 1'b1;
    launch(CMD_ERSSEC, 16'h0200, 16'h0000);
    wait_done;
    engine_fail <= 1'b0;
    chk_rd(OFS_STAT, 8'h81, "array failure reported");
    launch(CMD_SUML, 16'h0002, 16'h0000);
    wait_done;
    `CHK(margin_level, 2'd2, "user margin")
    launch(CMD_SFML, 16'h0001, 16'h0000);
    chk_rd(OFS_STAT, 8'hA0, "field margin refused");
    wr(OFS_STAT, 8'h30);
    special_mode <= 1'b1;
    launch(CMD_SFML, 16'h0001, 16'h0000);
    wait_done;
    `CHK(margin_level, 2'd1, "field margin")
    launch(CMD_PONCE, 16'h0005, 16'h005A);
    wait_done;
    launch(CMD_RONCE, 16'h0005, 16'h0000);
    wait_done;
    wr(OFS_PIDX, 8'h02);
    chk_rd(OFS_PLO, 8'h5A, "read once");
    launch(CMD_PONCE, 16'h0005, 16'h0011);
    chk_rd(OFS_STAT, 8'hA0, "second program once");
    wr(OFS_STAT, 8'h30);
    chk_rd(OFS_INFO, 8'h00, "info unmapped");
    map_sel <= 1'b1;
    chk_rd(OFS_INFO, 8'h5A, "info mapped");
    wr(OFS_ERRCFG, 8'h03);
    wr(OFS_CFG, 8'h02);
    fault(1'b0, 1'b0);
    chk_rd(OFS_ERRSTAT, 8'h02, "forced double");
    `CHK(error_irq, 1'b1, "error irq")
    wr(OFS_CFG, 8'h00);
    wr(OFS_ERRSTAT, 8'h03);
    chk_rd(OFS_CFG, 8'h00, "force cleared");
    `CHK(error_irq, 1'b0, "error irq cleared")
    wr(OFS_CFG, 8'h11);
    fault(1'b1, 1'b0);
    chk_rd(OFS_ERRSTAT, 8'h00, "single ignored");
    wr(OFS_CFG, 8'h01);
    wr(OFS_ERRCFG, 8'h02);
    fault(1'b0, 1'b0);
    chk_rd(OFS_ERRSTAT, 8'h01, "forced single");
    `CHK(error_irq, 1'b0, "single irq masked")
    wr(OFS_CFG, 8'h00);
    wr(OFS_ERRSTAT, 8'h03);
    fault(1'b0, 1'b0);
    chk_rd(OFS_ERRSTAT, 8'h00, "clean read");
    fault(1'b1, 1'b1);
    chk_rd(OFS_ERRSTAT, 8'h03, "real faults");
    `CHK(error_irq, 1'b1, "double irq")
    // Mid-run reset must forget the divider
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    s = starts;
    chk_rd(OFS_CLKDIV, 8'h00, "divider after reset");
    launch(CMD_ERSSEC, 16'h0100, 16'h0000);
    chk_rd(OFS_STAT, 8'hA0, "erase after reset");
    `CHK(starts, s, "start after reset")
    report_and_stop;
  end
endmodule // tb
